// ==== fmc_consts.vh ====
`ifndef FMC_CONSTS_VH
`define FMC_CONSTS_VH

// ********************************************************
// Register offsets in the special function register space
// ********************************************************
`define FMC_OFS_COMMAND     8'hB9
`define FMC_OFS_ACCESS_KEY  8'hBA
`define FMC_OFS_PROT_KEY    8'hBB
`define FMC_OFS_DATA        8'hBC
`define FMC_OFS_GUARD_LOW   8'hBD
`define FMC_OFS_GUARD_HIGH  8'hBE
`define FMC_OFS_READ_GUARD  8'hBF
`define FMC_OFS_ADDR_LOW    8'hC6
`define FMC_OFS_ADDR_HIGH   8'hC7

// ********************************************************
// Reset values
// ********************************************************
`define FMC_RST_COMMAND     8'h00
`define FMC_RST_ACCESS_KEY  8'hFF
`define FMC_RST_PROT_KEY    8'hFF
`define FMC_RST_DATA        8'h00
`define FMC_RST_GUARD       8'hFF
`define FMC_RST_ADDR        8'h00

// ********************************************************
// Command codes and results
// ********************************************************
`define FMC_CMD_WRITE       8'h01
`define FMC_CMD_ERASE_PAGE  8'h02
`define FMC_CMD_ERASE_ALL   8'h03
`define FMC_CMD_READ        8'h04
`define FMC_CMD_ERASE_WRITE 8'h05
`define FMC_CMD_PROTECT     8'h08
`define FMC_CMD_VERIFY      8'h0F
`define FMC_RES_OK          8'h00
`define FMC_RES_FAIL        8'h01

// ********************************************************
// Keys, erased value and protection area
// ********************************************************
`define FMC_ACCESS_KEY      8'h3B
`define FMC_ERASED          8'hFF
`define FMC_PADDR_KEY       14'h3FFA
`define FMC_PADDR_READ      14'h3FFB
`define FMC_PADDR_GUARD0    14'h3FFC
`define FMC_PADDR_GUARD1    14'h3FFD

// ********************************************************
// Cell timing in ref_clk cycles
// ********************************************************
`define FMC_ERASE_CYCLES    8'd20
`define FMC_PROG_CYCLES     8'd4

`endif

// ==== fmc_array.v ====
`timescale 1ns/1ps
`include "fmc_consts.vh"

// ********************************************************
// Flash cell array held in flip-flops
// ********************************************************
module fmc_array
#(
    parameter ADDR_W = 14,
    parameter PAGE_W = 9
)
(
    input wire ref_clk, // System clock
    input wire rst_n, // Asynchronous reset, active low
    input wire [ADDR_W-1:0] addr, // Byte address
    input wire [7:0] wdata, // Byte to program
    input wire prog_en, // Program pulse
    input wire page_erase_en, // Page erase pulse
    input wire mass_erase_en, // Mass erase pulse
    output wire [7:0] rdata, // Byte at addr
    output wire [47:0] prot_bytes // Last six bytes, lowest address in low byte
);

localparam DEPTH = 1 << ADDR_W;

reg [7:0] mem_q [0:DEPTH-1];
integer i;

assign rdata = mem_q[addr];

genvar g;
generate
    for (g = 0; g < 6; g = g + 1)
    begin : g_prot
        assign prot_bytes[8*g +: 8] = mem_q[DEPTH-6+g];
    end
endgenerate

always @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        for (i = 0; i < DEPTH; i = i + 1)
            mem_q[i] <= `FMC_ERASED;
    end
    else if (mass_erase_en)
    begin
        for (i = 0; i < DEPTH; i = i + 1)
            mem_q[i] <= `FMC_ERASED;
    end
    else if (page_erase_en)
    begin
        for (i = 0; i < DEPTH; i = i + 1)
            if (i[ADDR_W-1:PAGE_W] == addr[ADDR_W-1:PAGE_W])
                mem_q[i] <= `FMC_ERASED;
    end
    else if (prog_en)
    begin
        mem_q[addr] <= mem_q[addr] & wdata;
    end
end

endmodule // fmc_array

// ==== fmc_ctrl.v ====
`timescale 1ns/1ps
`include "fmc_consts.vh"

// Behaviour
// - Erased bytes read 0xFF; programming only clears bits.
// - No single-byte erase; a whole page is the smallest erase.
// - Array is 32 pages of 512 bytes, 16 kbytes.
// - Page erase and mass erase are both supported.
// - Page 31 holds per-page guard bytes and a read guard byte.
// - One protection-area byte holds the key for changing protection.
// - Last six bytes of page 31 are protection information.
// - Data register holds the byte; two address registers select it.
// - Access key register is reset after every operation.
// - Core is held on the command write until the operation ends.
// - Interrupts are deferred until the operation ends.
// - Peripherals keep running; only instruction execution stalls.
// - Command 1 programs the data byte at the address.
// - Command 2 erases the page holding the address.
// - Command 3 erases the whole array.
// - Command 4 reads the addressed byte into the data register.
// - Command 5 erases the page, then programs the byte.
// - Command 8 programs protection settings or key.
// - A verify command reports whether the addressed byte equals the data register.
// - A command runs only if the access key equals 0x3B.
// - Protection update needs matching stored key, unless stored key is 0xFF.
// - Command 8 with blank stored key programs the key, which stays until a mass erase, or a page erase of page 31 while its guard bit is set, blanks it.
// - Guard bit n covers one page; a cleared bit protects it.
module fmc_ctrl
#(
    parameter ADDR_W = 14,
    parameter PAGE_W = 9
)
(
    input wire ref_clk, // System clock, 100 MHz
    input wire rst_n, // Asynchronous reset, active low
    input wire [7:0] sfr_addr, // Register address
    input wire [7:0] sfr_wdata, // Register write data
    input wire sfr_wr, // Register write strobe
    output reg [7:0] sfr_rdata, // Register read data
    output wire core_hold, // Holds the program counter
    output wire irq_defer, // Keeps interrupt requests pending
    output wire flash_busy // Operation in progress
);

// ********************************************************
// States
// ********************************************************
localparam [2:0] S_IDLE = 3'd0;
localparam [2:0] S_ERASE = 3'd1;
localparam [2:0] S_PROG = 3'd2;
localparam [2:0] S_READ = 3'd3;
localparam [2:0] S_DONE = 3'd4;

// ********************************************************
// Array geometry
// ********************************************************
localparam PAGES = 1 << (ADDR_W - PAGE_W);

// ********************************************************
// Registers
// ********************************************************
reg [2:0] state_q;
reg [7:0] command_q;
reg [7:0] access_key_q;
reg [7:0] prot_key_q;
reg [7:0] data_q;
reg [7:0] guard_low_q;
reg [7:0] guard_high_q;
reg [7:0] read_guard_q;
reg [7:0] addr_low_q;
reg [7:0] addr_high_q;
reg [7:0] cnt_q;
reg [1:0] step_q;
reg mass_q;
reg then_prog_q;
reg prot_mode_q;
reg verify_q;
reg arr_prog_q;
reg arr_perase_q;
reg arr_merase_q;
reg [ADDR_W-1:0] arr_addr_q;
reg [7:0] arr_wdata_q;

wire [ADDR_W-1:0] op_addr;
wire [7:0] arr_rdata;
wire [47:0] prot_bytes;
wire [7:0] stored_key;
wire [PAGES-1:0] page_guard;
wire page_locked;
wire cmd_wr;
wire key_ok;
wire prot_ok;
reg [ADDR_W-1:0] prog_addr;
reg [7:0] prog_data;

// ********************************************************
// Flash array
// ********************************************************
fmc_array #(
    .ADDR_W(ADDR_W),
    .PAGE_W(PAGE_W)
) u_array (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .addr(arr_addr_q),
    .wdata(arr_wdata_q),
    .prog_en(arr_prog_q),
    .page_erase_en(arr_perase_q),
    .mass_erase_en(arr_merase_q),
    .rdata(arr_rdata),
    .prot_bytes(prot_bytes)
);

// ********************************************************
// Address and protection decode
// ********************************************************
// High address bits above the array are ignored
assign op_addr = {addr_high_q[ADDR_W-9:0], addr_low_q};
assign stored_key = prot_bytes[7:0];
assign page_guard = prot_bytes[47:16];
assign page_locked = ~page_guard[op_addr[ADDR_W-1:PAGE_W]];
assign cmd_wr = sfr_wr && (sfr_addr == `FMC_OFS_COMMAND) && (state_q == S_IDLE);
assign key_ok = (access_key_q == `FMC_ACCESS_KEY);
assign prot_ok = (stored_key == `FMC_ERASED) || (prot_key_q == stored_key);

// ********************************************************
// Core and interrupt hold from the command write to the end of the operation
// ********************************************************
assign flash_busy = (state_q != S_IDLE);
assign core_hold = flash_busy || cmd_wr;
assign irq_defer = flash_busy || cmd_wr;

// ********************************************************
// Protection sequence: key, read guard, guard low, guard high
// ********************************************************
always @*
begin
    prog_addr = op_addr;
    prog_data = data_q;
    if (prot_mode_q)
    begin
        case (step_q)
            2'd0:
            begin
                prog_addr = `FMC_PADDR_KEY;
                prog_data = (stored_key == `FMC_ERASED) ? prot_key_q : `FMC_ERASED;
            end
            2'd1:
            begin
                prog_addr = `FMC_PADDR_READ;
                prog_data = read_guard_q;
            end
            2'd2:
            begin
                prog_addr = `FMC_PADDR_GUARD0;
                prog_data = guard_low_q;
            end
            default:
            begin
                prog_addr = `FMC_PADDR_GUARD1;
                prog_data = guard_high_q;
            end
        endcase
    end
end

// ********************************************************
// Register read
// ********************************************************
always @*
begin
    case (sfr_addr)
        `FMC_OFS_COMMAND: sfr_rdata = command_q;
        `FMC_OFS_ACCESS_KEY: sfr_rdata = access_key_q;
        `FMC_OFS_PROT_KEY: sfr_rdata = prot_key_q;
        `FMC_OFS_DATA: sfr_rdata = data_q;
        `FMC_OFS_GUARD_LOW: sfr_rdata = guard_low_q;
        `FMC_OFS_GUARD_HIGH: sfr_rdata = guard_high_q;
        `FMC_OFS_READ_GUARD: sfr_rdata = read_guard_q;
        `FMC_OFS_ADDR_LOW: sfr_rdata = addr_low_q;
        `FMC_OFS_ADDR_HIGH: sfr_rdata = addr_high_q;
        default: sfr_rdata = 8'h00;
    endcase
end

// ********************************************************
// Register write and operation sequencer
// ********************************************************
// Only core execution is held; nothing here gates other peripherals
always @(posedge ref_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        state_q <= S_IDLE;
        command_q <= `FMC_RST_COMMAND;
        access_key_q <= `FMC_RST_ACCESS_KEY;
        prot_key_q <= `FMC_RST_PROT_KEY;
        data_q <= `FMC_RST_DATA;
        guard_low_q <= `FMC_RST_GUARD;
        guard_high_q <= `FMC_RST_GUARD;
        read_guard_q <= `FMC_RST_GUARD;
        addr_low_q <= `FMC_RST_ADDR;
        addr_high_q <= `FMC_RST_ADDR;
        cnt_q <= 8'h00;
        step_q <= 2'd0;
        mass_q <= 1'b0;
        then_prog_q <= 1'b0;
        prot_mode_q <= 1'b0;
        verify_q <= 1'b0;
        arr_prog_q <= 1'b0;
        arr_perase_q <= 1'b0;
        arr_merase_q <= 1'b0;
        arr_addr_q <= {ADDR_W{1'b0}};
        arr_wdata_q <= 8'h00;
    end
    else
    begin
        arr_prog_q <= 1'b0;
        arr_perase_q <= 1'b0;
        arr_merase_q <= 1'b0;
        if (sfr_wr && (state_q == S_IDLE))
        begin
            case (sfr_addr)
                `FMC_OFS_ACCESS_KEY: access_key_q <= sfr_wdata;
                `FMC_OFS_PROT_KEY: prot_key_q <= sfr_wdata;
                `FMC_OFS_DATA: data_q <= sfr_wdata;
                `FMC_OFS_GUARD_LOW: guard_low_q <= sfr_wdata;
                `FMC_OFS_GUARD_HIGH: guard_high_q <= sfr_wdata;
                `FMC_OFS_READ_GUARD: read_guard_q <= sfr_wdata;
                `FMC_OFS_ADDR_LOW: addr_low_q <= sfr_wdata;
                `FMC_OFS_ADDR_HIGH: addr_high_q <= sfr_wdata;
                default: ;
            endcase
        end
        case (state_q)
            S_IDLE:
            begin
                if (cmd_wr)
                begin
                    // Result reads fail until an accepted operation completes
                    command_q <= `FMC_RES_FAIL;
                    access_key_q <= `FMC_RST_ACCESS_KEY;
                    arr_addr_q <= op_addr[ADDR_W-1:0];
                    arr_wdata_q <= data_q;
                    mass_q <= 1'b0;
                    then_prog_q <= 1'b0;
                    prot_mode_q <= 1'b0;
                    verify_q <= 1'b0;
                    step_q <= 2'd0;
                    cnt_q <= 8'h00;
                    if (key_ok)
                    begin
                        case (sfr_wdata)
                            `FMC_CMD_WRITE:
                                if (!page_locked)
                                    state_q <= S_PROG;
                            `FMC_CMD_ERASE_PAGE:
                                if (!page_locked)
                                    state_q <= S_ERASE;
                            `FMC_CMD_ERASE_ALL:
                            begin
                                mass_q <= 1'b1;
                                state_q <= S_ERASE;
                            end
                            `FMC_CMD_READ:
                                state_q <= S_READ;
                            `FMC_CMD_ERASE_WRITE:
                                if (!page_locked)
                                begin
                                    then_prog_q <= 1'b1;
                                    state_q <= S_ERASE;
                                end
                            `FMC_CMD_VERIFY:
                            begin
                                verify_q <= 1'b1;
                                state_q <= S_READ;
                            end
                            `FMC_CMD_PROTECT:
                                if (prot_ok)
                                begin
                                    prot_mode_q <= 1'b1;
                                    state_q <= S_PROG;
                                end
                            default: ;
                        endcase
                    end
                end
            end
            S_ERASE:
            begin
                if (cnt_q == `FMC_ERASE_CYCLES - 8'd1)
                begin
                    cnt_q <= 8'h00;
                    arr_merase_q <= mass_q;
                    arr_perase_q <= ~mass_q;
                    state_q <= then_prog_q ? S_PROG : S_DONE;
                end
                else
                    cnt_q <= cnt_q + 8'd1;
            end
            S_PROG:
            begin
                if (cnt_q == `FMC_PROG_CYCLES - 8'd1)
                begin
                    cnt_q <= 8'h00;
                    arr_prog_q <= 1'b1;
                    arr_addr_q <= prog_addr;
                    arr_wdata_q <= prog_data;
                    if (prot_mode_q && (step_q != 2'd3))
                        step_q <= step_q + 2'd1;
                    else
                        state_q <= S_DONE;
                end
                else
                    cnt_q <= cnt_q + 8'd1;
            end
            S_READ:
            begin
                if (verify_q)
                    command_q <= (arr_rdata == data_q) ? `FMC_RES_OK : `FMC_RES_FAIL;
                else
                    data_q <= arr_rdata;
                state_q <= S_DONE;
            end
            S_DONE:
            begin
                if (!verify_q)
                    command_q <= `FMC_RES_OK;
                // Every finished operation needs a fresh key
                access_key_q <= `FMC_RST_ACCESS_KEY;
                arr_addr_q <= op_addr[ADDR_W-1:0];
                state_q <= S_IDLE;
            end
            default:
                state_q <= S_IDLE;
        endcase
    end
end

endmodule // fmc_ctrl

// ==== fmc_ctrl_chk.sv ====
`timescale 1ns/1ps
`include "fmc_consts.vh"

// ****************
// Port checker
// ****************
module fmc_ctrl_chk
(
    input wire ref_clk, // Clock
    input wire rst_n, // Reset, active low
    input wire [7:0] sfr_addr, // Register address
    input wire [7:0] sfr_wdata, // Write data
    input wire sfr_wr, // Write strobe
    input wire [7:0] sfr_rdata, // Read data
    input wire core_hold, // Core stall
    input wire irq_defer, // Interrupt defer
    input wire flash_busy // Busy
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    reg [7:0] key_q;
    reg [7:0] cmd_q;
    reg [7:0] cnt_q;
    reg clr_q;
    wire take = sfr_wr && sfr_addr == 8'hB9 && !flash_busy;
    wire key_wr = sfr_wr && sfr_addr == 8'hBA && !flash_busy;
    wire ok = take && key_q == 8'h3B;
    wire fast = sfr_wdata == 8'h03 || sfr_wdata == 8'h04 || sfr_wdata == 8'h0F;
    wire known = fast || sfr_wdata == 8'h01 || sfr_wdata == 8'h02 || sfr_wdata == 8'h05 || sfr_wdata == 8'h08;

    // Mirror of the access key and length of the running operation
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            key_q <= 8'hFF;
            cmd_q <= 8'h00;
            cnt_q <= 8'h00;
            clr_q <= 1'b0;
        end
        else
        begin
            cnt_q <= flash_busy ? cnt_q + 8'd1 : 8'd0;
            if (take)
            begin
                key_q <= 8'hFF;
                cmd_q <= sfr_wdata;
                clr_q <= 1'b1;
            end
            else if (key_wr)
            begin
                key_q <= sfr_wdata;
                clr_q <= 1'b0;
            end
        end
    end

    a_defer_hold: assert property (irq_defer == core_hold) else $error("defer differs from hold");
    a_hold_busy: assert property (flash_busy |-> core_hold) else $error("busy without hold");
    a_hold_cmd: assert property (ok && fast |-> core_hold ##1 flash_busy) else $error("command not held");
    a_no_key: assert property (take && key_q != 8'h3B |=> !flash_busy) else $error("ran without key");
    a_bad_code: assert property (ok && !known |=> !flash_busy) else $error("unlisted code ran");
    a_key_reset: assert property (clr_q && !flash_busy && !sfr_wr && sfr_addr == 8'hBA |-> sfr_rdata == 8'hFF)
        else $error("key not cleared");
    a_read_len: assert property ($fell(flash_busy) && (cmd_q == 8'h04 || cmd_q == 8'h0F) |-> cnt_q == 8'd2)
        else $error("read length");
    a_prog_len: assert property ($fell(flash_busy) && cmd_q == 8'h01 |-> cnt_q == `FMC_PROG_CYCLES + 8'd1)
        else $error("write length");
    a_erase_len: assert property ($fell(flash_busy) && (cmd_q == 8'h02 || cmd_q == 8'h03)
        |-> cnt_q == `FMC_ERASE_CYCLES + 8'd1) else $error("erase length");
    a_ew_len: assert property ($fell(flash_busy) && cmd_q == 8'h05
        |-> cnt_q == `FMC_ERASE_CYCLES + `FMC_PROG_CYCLES + 8'd1) else $error("erase-write length");
    a_prot_len: assert property ($fell(flash_busy) && cmd_q == 8'h08 |-> cnt_q == 8'd17)
        else $error("protect length");
    c_protect: cover property (ok && sfr_wdata == 8'h08);
    c_mass: cover property ($fell(flash_busy) && cmd_q == 8'h03);
    c_no_key: cover property (take && key_q != 8'h3B);
endmodule // fmc_ctrl_chk

bind fmc_ctrl fmc_ctrl_chk u_fmc_ctrl_chk (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata), .core_hold(core_hold),
    .irq_defer(irq_defer), .flash_busy(flash_busy));

// ==== fmc_core_model.sv ====
`timescale 1ns/1ps

// ****************
// Core model
// ****************
module fmc_core_model
(
    input wire ref_clk, // Clock
    input wire core_hold, // Stall from controller
    input wire [7:0] sfr_rdata, // Read data
    output reg [7:0] sfr_addr, // Register address
    output reg [7:0] sfr_wdata, // Write data
    output reg sfr_wr, // Write strobe
    output reg rd_seen, // Read value captured
    output reg [7:0] rd_val // Captured read value
);
    initial
    begin
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        rd_seen = 1'b0;
        rd_val = 8'h00;
    end

    // A stalled core issues nothing until the hold drops
    task wait_free;
    begin
        @(posedge ref_clk);
        #1;
        while (core_hold === 1'b1)
        begin
            @(posedge ref_clk);
            #1;
        end
    end
    endtask

    task write_reg(input [7:0] a, input [7:0] d);
    begin
        wait_free;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        sfr_wr = 1'b0;
        sfr_addr = ~a;
        sfr_wdata = ~d;
    end
    endtask

    task read_reg(input [7:0] a);
    begin
        wait_free;
        sfr_addr = a;
        @(posedge ref_clk);
        rd_val <= sfr_rdata;
        rd_seen <= 1'b1;
        @(posedge ref_clk);
        rd_seen <= 1'b0;
        #1;
        sfr_addr = ~a;
    end
    endtask

    task command(input [7:0] c);
    begin
        write_reg(8'hBA, 8'h3B);
        write_reg(8'hB9, c);
    end
    endtask
endmodule // fmc_core_model

// ==== flash_memory_controller_tb.sv ====
`timescale 1ns/1ps

// ****************
// Testbench
// ****************
module flash_memory_controller_tb;
    localparam [79:0] OFS = {8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'hC6, 8'hC7, 8'h00};
    localparam [79:0] RST = {8'h00, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
    reg ref_clk = 1'b0;
    reg rst_n = 1'b0;
    wire [7:0] sfr_addr;
    wire [7:0] sfr_wdata;
    wire [7:0] sfr_rdata;
    wire [7:0] rd_val;
    wire sfr_wr;
    wire core_hold;
    wire rd_seen;
    integer miscompares = 0;
    integer comparisons = 0;
    integer cycles = 0;
    integer seed = 32'h8c977d2a;
    integer i;
    reg [7:0] exp_q[$];
    reg [13:0] a0, a2, pa;
    reg [7:0] d0, d1, g;
    reg [2:0] p;

    fmc_ctrl u_fmc_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
        .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata), .core_hold(core_hold), .irq_defer(), .flash_busy());
    fmc_core_model u_fmc_core_model (.ref_clk(ref_clk), .core_hold(core_hold), .sfr_rdata(sfr_rdata),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .rd_seen(rd_seen), .rd_val(rd_val));

    always #5 ref_clk = ~ref_clk;

    task finish_test;
    begin
        if (miscompares == 0 && comparisons > 0 && exp_q.size() == 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask

    always @(posedge ref_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t timeout", $time);
            finish_test;
        end
    end

    // Compares each captured read with the oldest expectation
    always @(posedge ref_clk)
    begin
        if (rd_seen === 1'b1)
        begin
            comparisons = comparisons + 1;
            if (exp_q.size() == 0 || rd_val !== exp_q[0])
            begin
                miscompares = miscompares + 1;
                $display("[ERR] %0t read got %h", $time, rd_val);
            end
            if (exp_q.size() != 0)
                void'(exp_q.pop_front());
        end
    end

    task wr(input [7:0] a, input [7:0] d);
        u_fmc_core_model.write_reg(a, d);
    endtask

    task chk(input [7:0] a, input [7:0] e);
    begin
        exp_q.push_back(e);
        u_fmc_core_model.read_reg(a);
    end
    endtask

    task fset(input [13:0] a);
    begin
        wr(8'hC7, {2'b00, a[13:8]});
        wr(8'hC6, a[7:0]);
    end
    endtask

    task fwrite(input [13:0] a, input [7:0] d, input [7:0] c);
    begin
        fset(a);
        wr(8'hBC, d);
        u_fmc_core_model.command(c);
    end
    endtask

    task fread(input [13:0] a, input [7:0] e);
    begin
        fwrite(a, 8'h00, 8'h04);
        chk(8'hBC, e);
        chk(8'hB9, 8'h00);
    end
    endtask

    initial
    begin
        repeat (8) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        for (i = 0; i < 10; i = i + 1)
            chk(OFS[i*8 +: 8], RST[i*8 +: 8]);
        a0 = 14'h1000 + 14'({$random(seed)} % 32'h2C00);
        a2 = a0 ^ 14'h0200;
        d0 = 8'($random(seed));
        d1 = 8'($random(seed));
        p = 3'($random(seed));
        pa = {2'b00, p, 9'($random(seed))};
        fread(a0, 8'hFF);
        fwrite(a0, d0, 8'h01);
        fread(a0, d0);
        fwrite(a0, d1, 8'h01);
        fread(a0, d0 & d1);
        chk(8'hBA, 8'hFF);
        wr(8'hBC, 8'h00);
        wr(8'hB9, 8'h01);
        chk(8'hB9, 8'h01);
        fread(a0, d0 & d1);
        wr(8'hBA, 8'h3B);
        wr(8'hB9, 8'h06);
        chk(8'hB9, 8'h01);
        chk(8'hBA, 8'hFF);
        fwrite(a0, d0 & d1, 8'h0F);
        chk(8'hB9, 8'h00);
        fwrite(a0, ~(d0 & d1), 8'h0F);
        chk(8'hB9, 8'h01);
        fwrite(a0 ^ 14'h0001, d0, 8'h01);
        fwrite(a0, d1, 8'h05);
        fread(a0, d1);
        fread(a0 ^ 14'h0001, 8'hFF);
        fwrite(a2, d0, 8'h01);
        fwrite(a2 ^ 14'h01FF, d1, 8'h02);
        fread(a2, 8'hFF);
        fread(a0, d1);
        fwrite(14'h3FFF, 8'h7F, 8'h01);
        fread(14'h3FFF, 8'h7F);
        g = ~(8'h01 << p);
        wr(8'hBD, g);
        wr(8'hBB, 8'h5A);
        u_fmc_core_model.command(8'h08);
        chk(8'hB9, 8'h00);
        fread(14'h3FFC, g);
        fread(14'h3FFA, 8'h5A);
        fwrite(pa, 8'h00, 8'h01);
        chk(8'hB9, 8'h01);
        fwrite(pa, 8'h00, 8'h02);
        chk(8'hB9, 8'h01);
        fread(pa, 8'hFF);
        wr(8'hBD, 8'hFF);
        wr(8'hBB, 8'hA5);
        u_fmc_core_model.command(8'h08);
        chk(8'hB9, 8'h01);
        fread(14'h3FFC, g);
        u_fmc_core_model.command(8'h03);
        fread(14'h3FFA, 8'hFF);
        fread(a0, 8'hFF);
        fwrite(pa, d0, 8'h01);
        fread(pa, d0);
        finish_test;
    end
endmodule // flash_memory_controller_tb
